/* File: inc/crtc_pkg.sv */
// Purpose: shared constants for the raster timing controller
// Assumes: AXI4-Lite register window, one system clock
// Notes: register indices follow the index/data access scheme

package crtc_pkg;

  // ----------------------------------------
  // bus window
  // ----------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFF_INDEX = 4'h0;
  localparam logic [3:0] OFF_DATA = 4'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // control register indices
  // ----------------------------------------
  localparam logic [4:0] IX_HTOTAL = 5'h00;
  localparam logic [4:0] IX_HSHOWN = 5'h01;
  localparam logic [4:0] IX_HSYNC_POS = 5'h02;
  localparam logic [4:0] IX_HSYNC_WIDTH = 5'h03;
  localparam logic [4:0] IX_VTOTAL = 5'h04;
  localparam logic [4:0] IX_VADJUST = 5'h05;
  localparam logic [4:0] IX_VSHOWN = 5'h06;
  localparam logic [4:0] IX_VSYNC_POS = 5'h07;
  localparam logic [4:0] IX_SCAN_MODE = 5'h08;
  localparam logic [4:0] IX_MAX_SCAN = 5'h09;
  localparam logic [4:0] IX_CUR_START = 5'h0a;
  localparam logic [4:0] IX_CUR_END = 5'h0b;
  localparam logic [4:0] IX_START_HI = 5'h0c;
  localparam logic [4:0] IX_START_LO = 5'h0d;
  localparam logic [4:0] IX_CURSOR_HI = 5'h0e;
  localparam logic [4:0] IX_CURSOR_LO = 5'h0f;
  localparam logic [4:0] IX_PEN_HI = 5'h10;
  localparam logic [4:0] IX_PEN_LO = 5'h11;

  // ----------------------------------------
  // fields and timing
  // ----------------------------------------
  localparam int CUR_MODE_LSB = 5;
  localparam logic [1:0] CUR_STEADY = 2'h0;
  localparam logic [1:0] CUR_HIDDEN = 2'h1;
  localparam logic [1:0] CUR_BLINK16 = 2'h2;
  localparam logic [1:0] CUR_BLINK32 = 2'h3;
  localparam int BLINK16_BIT = 4;
  localparam int BLINK32_BIT = 5;
  localparam logic [3:0] VSYNC_LINES = 4'hf;
  localparam int CHAR_DIV_DEFAULT = 4;

  typedef enum {SCAN_PLAIN, SCAN_SYNC, SCAN_VIDEO} crtc_scan_t;

endpackage : crtc_pkg

/* File: design/crtc_raster_timing.sv */
// Purpose: character-clocked raster timing generator with AXI4-Lite registers
// Assumes: character period is CHAR_DIV system clocks; pen strobe is synchronous
// Notes: control registers keep their contents across reset, except the index register and the pen address, which clear

module crtc_raster_timing #(
  parameter int CHAR_DIV = crtc_pkg::CHAR_DIV_DEFAULT
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [crtc_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [crtc_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic penStrobeIn,
  output logic hsync,
  output logic vsync,
  output logic displayWindow,
  output logic cursorVideo,
  output logic [13:0] refreshAddr,
  output logic [4:0] scanlineIndex
);

  // ----------------------------------------
  // control registers (no reset on purpose, except index and pen address)
  // ----------------------------------------
  logic [4:0] indexReg;
  logic [7:0] hTotal, hShown, hsyncPos;
  logic [3:0] hsyncWidth;
  logic [6:0] vTotal, vShown, vsyncPos, curStart;
  logic [4:0] vAdjust, maxScan, curEnd;
  logic [1:0] scanMode;
  logic [13:0] startAddr, cursorAddr, penAddr;

  logic wrFire, rdFire, wrData;
  assign awready = awvalid && wvalid && !bvalid;
  assign wready = awready;
  assign wrFire = awvalid && wvalid && !bvalid;
  assign wrData = wrFire && awaddr == crtc_pkg::OFF_DATA && wstrb[0];
  assign arready = !rvalid;
  assign rdFire = arvalid && !rvalid;

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      indexReg <= 5'h00;
    else if (wrFire && awaddr == crtc_pkg::OFF_INDEX && wstrb[0])
      indexReg <= wdata[4:0];

  // counters reset, these do not
  always_ff @(posedge clk)
    if (wrData)
    begin
      unique case (indexReg)
        crtc_pkg::IX_HTOTAL: hTotal <= wdata[7:0];
        crtc_pkg::IX_HSHOWN: hShown <= wdata[7:0];
        crtc_pkg::IX_HSYNC_POS: hsyncPos <= wdata[7:0];
        crtc_pkg::IX_HSYNC_WIDTH: hsyncWidth <= wdata[3:0];
        crtc_pkg::IX_VTOTAL: vTotal <= wdata[6:0];
        crtc_pkg::IX_VADJUST: vAdjust <= wdata[4:0];
        crtc_pkg::IX_VSHOWN: vShown <= wdata[6:0];
        crtc_pkg::IX_VSYNC_POS: vsyncPos <= wdata[6:0];
        crtc_pkg::IX_SCAN_MODE: scanMode <= wdata[1:0];
        crtc_pkg::IX_MAX_SCAN: maxScan <= wdata[4:0];
        crtc_pkg::IX_CUR_START: curStart <= wdata[6:0];
        crtc_pkg::IX_CUR_END: curEnd <= wdata[4:0];
        crtc_pkg::IX_START_HI: startAddr[13:8] <= wdata[5:0];
        crtc_pkg::IX_START_LO: startAddr[7:0] <= wdata[7:0];
        crtc_pkg::IX_CURSOR_HI: cursorAddr[13:8] <= wdata[5:0];
        crtc_pkg::IX_CURSOR_LO: cursorAddr[7:0] <= wdata[7:0];
        default: ; // pen registers are read only, 18..31 do nothing
      endcase
    end

  // ----------------------------------------
  // bus answers
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      bvalid <= 1'b0;
      bresp <= crtc_pkg::RESP_OKAY;
    end
    else if (wrFire)
    begin
      bvalid <= 1'b1;
      bresp <= (awaddr == crtc_pkg::OFF_INDEX || awaddr == crtc_pkg::OFF_DATA) ?
               crtc_pkg::RESP_OKAY : crtc_pkg::RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;

  logic [7:0] rdByte;
  always_comb
  begin
    rdByte = 8'h00;
    unique case (indexReg)
      crtc_pkg::IX_HTOTAL: rdByte = hTotal;
      crtc_pkg::IX_HSHOWN: rdByte = hShown;
      crtc_pkg::IX_HSYNC_POS: rdByte = hsyncPos;
      crtc_pkg::IX_HSYNC_WIDTH: rdByte = {4'h0, hsyncWidth};
      crtc_pkg::IX_VTOTAL: rdByte = {1'b0, vTotal};
      crtc_pkg::IX_VADJUST: rdByte = {3'h0, vAdjust};
      crtc_pkg::IX_VSHOWN: rdByte = {1'b0, vShown};
      crtc_pkg::IX_VSYNC_POS: rdByte = {1'b0, vsyncPos};
      crtc_pkg::IX_SCAN_MODE: rdByte = {6'h00, scanMode};
      crtc_pkg::IX_MAX_SCAN: rdByte = {3'h0, maxScan};
      crtc_pkg::IX_CUR_START: rdByte = {1'b0, curStart};
      crtc_pkg::IX_CUR_END: rdByte = {3'h0, curEnd};
      crtc_pkg::IX_START_HI: rdByte = {2'h0, startAddr[13:8]};
      crtc_pkg::IX_START_LO: rdByte = startAddr[7:0];
      crtc_pkg::IX_CURSOR_HI: rdByte = {2'h0, cursorAddr[13:8]};
      crtc_pkg::IX_CURSOR_LO: rdByte = cursorAddr[7:0];
      crtc_pkg::IX_PEN_HI: rdByte = {2'h0, penAddr[13:8]};
      crtc_pkg::IX_PEN_LO: rdByte = penAddr[7:0];
      default: rdByte = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= crtc_pkg::RESP_OKAY;
    end
    else if (rdFire)
    begin
      rvalid <= 1'b1;
      rresp <= crtc_pkg::RESP_OKAY;
      if (araddr == crtc_pkg::OFF_INDEX)
        rdata <= {27'h0, indexReg};
      else if (araddr == crtc_pkg::OFF_DATA)
        rdata <= {24'h0, rdByte};
      else
      begin
        rdata <= 32'h0;
        rresp <= crtc_pkg::RESP_SLVERR;
      end
    end
    else if (rready)
      rvalid <= 1'b0;

  // ----------------------------------------
  // character tick from the system clock
  // ----------------------------------------
  logic [7:0] divCnt;
  logic tick;
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      divCnt <= 8'h00;
      tick <= 1'b0;
    end
    else
    begin
      tick <= divCnt == 8'(CHAR_DIV - 1);
      divCnt <= (divCnt == 8'(CHAR_DIV - 1)) ? 8'h00 : divCnt + 8'h01;
    end

  // ----------------------------------------
  // raster counters
  // ----------------------------------------
  crtc_pkg::crtc_scan_t liveMode, frameMode;
  always_comb
    if (!scanMode[0])
      liveMode = crtc_pkg::SCAN_PLAIN;
    else if (scanMode[1])
      liveMode = crtc_pkg::SCAN_VIDEO;
    else
      liveMode = crtc_pkg::SCAN_SYNC;

  logic [7:0] hCount;
  logic [6:0] row;
  logic [4:0] scan, adjCnt;
  logic [13:0] ma, lineStart;
  logic field, inAdjust;
  logic [5:0] fieldCnt;
  logic lineEnd, rowLast, frameEnd, nextField;

  assign lineEnd = tick && hCount == hTotal;
  // video interlace ends a row on the pair that holds the max scanline
  assign rowLast = (frameMode == crtc_pkg::SCAN_VIDEO) ?
                   ((scan | 5'h01) >= maxScan) : (scan >= maxScan);
  assign frameEnd = lineEnd && (inAdjust ? (adjCnt == vAdjust - 5'h01) :
                    (rowLast && row == vTotal && vAdjust == 5'h00));
  assign nextField = (liveMode != crtc_pkg::SCAN_PLAIN) && !field;

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      hCount <= 8'h00;
      row <= 7'h00;
      scan <= 5'h00;
      adjCnt <= 5'h00;
      ma <= 14'h0000;
      lineStart <= 14'h0000;
      field <= 1'b0;
      inAdjust <= 1'b0;
      fieldCnt <= 6'h00;
      frameMode <= crtc_pkg::SCAN_PLAIN;
    end
    else if (frameEnd)
    begin
      hCount <= 8'h00;
      row <= 7'h00;
      inAdjust <= 1'b0;
      field <= nextField;
      frameMode <= liveMode;
      scan <= (liveMode == crtc_pkg::SCAN_VIDEO) ? {4'h0, nextField} : 5'h00;
      lineStart <= startAddr;
      ma <= startAddr;
      fieldCnt <= fieldCnt + 6'h01;
    end
    else if (lineEnd)
    begin
      hCount <= 8'h00;
      if (inAdjust)
      begin
        adjCnt <= adjCnt + 5'h01;
        scan <= scan + 5'h01;
        ma <= lineStart;
      end
      else if (rowLast)
      begin
        row <= row + 7'h01;
        scan <= (frameMode == crtc_pkg::SCAN_VIDEO) ? {4'h0, field} : 5'h00;
        if (row == vTotal)
        begin
          inAdjust <= 1'b1;
          adjCnt <= 5'h00;
        end
        lineStart <= lineStart + 14'(hShown);
        ma <= lineStart + 14'(hShown);
      end
      else
      begin
        // identical scanlines in both fields unless video interlace
        scan <= scan + ((frameMode == crtc_pkg::SCAN_VIDEO) ? 5'h02 : 5'h01);
        ma <= lineStart;
      end
    end
    else if (tick)
    begin
      hCount <= hCount + 8'h01;
      ma <= ma + 14'h0001;
    end

  assign refreshAddr = ma;
  assign scanlineIndex = scan;

  // ----------------------------------------
  // sync pulses
  // ----------------------------------------
  logic [3:0] hsCnt, vsCnt;
  logic [6:0] nextRow;
  assign nextRow = frameEnd ? 7'h00 : row + 7'h01;

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      hsync <= 1'b0;
      hsCnt <= 4'h0;
    end
    else if (tick)
    begin
      if (hsync)
      begin
        hsync <= hsCnt != hsyncWidth - 4'h1;
        hsCnt <= hsCnt + 4'h1;
      end
      else if (hCount == hsyncPos && hsyncWidth != 4'h0)
      begin
        hsync <= 1'b1;
        hsCnt <= 4'h0;
      end
    end

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      vsync <= 1'b0;
      vsCnt <= 4'h0;
    end
    else if (lineEnd)
    begin
      if (vsync)
      begin
        vsync <= vsCnt != crtc_pkg::VSYNC_LINES;
        vsCnt <= vsCnt + 4'h1;
      end
      else if ((frameEnd || (rowLast && !inAdjust)) && nextRow == vsyncPos)
      begin
        vsync <= 1'b1;
        vsCnt <= 4'h0;
      end
    end

  // ----------------------------------------
  // window, cursor, light pen
  // ----------------------------------------
  logic blinkOk, inWindow;
  always_comb
    unique case (curStart[6:crtc_pkg::CUR_MODE_LSB])
      crtc_pkg::CUR_STEADY: blinkOk = 1'b1;
      crtc_pkg::CUR_HIDDEN: blinkOk = 1'b0;
      crtc_pkg::CUR_BLINK16: blinkOk = fieldCnt[crtc_pkg::BLINK16_BIT];
      crtc_pkg::CUR_BLINK32: blinkOk = fieldCnt[crtc_pkg::BLINK32_BIT];
    endcase

  assign inWindow = hCount < hShown && row < vShown && !inAdjust;

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      displayWindow <= 1'b0;
      cursorVideo <= 1'b0;
    end
    else
    begin
      displayWindow <= inWindow;
      cursorVideo <= inWindow && blinkOk && ma == cursorAddr &&
                     scan >= curStart[4:0] && scan <= curEnd;
    end

  // capture repeats every clock while the strobe stays high, last address wins
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      penAddr <= 14'h0000;
    else if (penStrobeIn)
      penAddr <= ma;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_vs_start;
    !vsync ##1 vsync;
  endsequence

  a_vsync_width: assert property (vsync && lineEnd && vsCnt == 4'hf |=> !vsync)
    else $error("vertical sync longer than sixteen lines");
  a_vsync_hold: assert property (s_vs_start |-> vsCnt == 4'h0)
    else $error("vertical sync started with stale count");
  a_addr_step: assert property (tick && !lineEnd |=> ma == $past(ma) + 14'h0001)
    else $error("refresh address did not advance");
  a_sync_same: assert property (lineEnd && !rowLast && !inAdjust &&
    frameMode == crtc_pkg::SCAN_SYNC |=> scan == $past(scan) + 5'h01)
    else $error("interlace sync scanline step wrong");
  a_video_parity: assert property (frameMode == crtc_pkg::SCAN_VIDEO && !inAdjust
    |-> scan[0] == field)
    else $error("scanline parity does not match field");
  a_index_write: assert property (wrData && indexReg == crtc_pkg::IX_HTOTAL
    |=> hTotal == $past(wdata[7:0]))
    else $error("indexed write not stored");
  a_write_answer: assert property (wrFire |=> bvalid)
    else $error("write response missing");
  a_cursor_gate: assert property (cursorVideo |-> displayWindow)
    else $error("cursor outside display window");
  a_hidden_cursor: assert property (cursorVideo |->
    $past(curStart[6:5]) != crtc_pkg::CUR_HIDDEN)
    else $error("hidden cursor shown");
  a_pen_capture: assert property (penStrobeIn |=> penAddr == $past(ma))
    else $error("pen address not captured");
  a_window_cols: assert property (displayWindow |-> $past(hCount < hShown))
    else $error("window outside shown columns");

endmodule : crtc_raster_timing

/* File: verif/crtc_pen_model.sv */
// Purpose: display-side stand-in that fires the light pen at one address
// Assumes: strobe is sampled by the controller on its own clock
// Notes: strobe is high only while the target address is on the bus

module crtc_pen_model (
  input wire logic arm,
  input wire logic [13:0] target,
  input wire logic [13:0] refreshAddr,
  output logic penStrobeIn
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // pen detector
  // ----------------------------------------
  // follows the beam, so any capture taken while high must equal target
  assign penStrobeIn = arm && (refreshAddr == target);
endmodule : crtc_pen_model

/* File: verif/tb.sv */
// Purpose: self-checking bench for the raster timing controller
// Assumes: CHAR_DIV of 2, bready and rready held high
// Notes: raster checks count per field between vsync rises

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 90000;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic penArm = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, penStrobeIn;
  logic hsync, vsync, displayWindow, cursorVideo;
  logic [1:0] bresp, rresp, sResp, pm, lpm, p1;
  logic [31:0] rdata, sData;
  logic [13:0] refreshAddr, pAddr;
  logic [4:0] scanlineIndex;
  logic pvs;
  int numErrors = 0;
  int checkCount = 0;
  int cycles = 0;
  int fieldNo = 0;
  int vsC, dwC, cuC, chC, lvs, ldw, lcu, lch, vis;
  int ddC, hsC, ldd, lhs;
  logic [1:0] dwPipe = 2'h0;
  logic [7:0] wv [18];
  logic [7:0] ev [18];
  logic [7:0] cm [3];
  int nf [3];
  int bx [3];

  always #2 clk = ~clk;

  crtc_raster_timing #(.CHAR_DIV(2)) uut (
    .clk(clk), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(1'b1), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(1'b1),
    .penStrobeIn(penStrobeIn), .hsync(hsync), .vsync(vsync),
    .displayWindow(displayWindow), .cursorVideo(cursorVideo),
    .refreshAddr(refreshAddr), .scanlineIndex(scanlineIndex)
  );

  crtc_pen_model pen (
    .arm(penArm), .target(14'h0021), .refreshAddr(refreshAddr), .penStrobeIn(penStrobeIn)
  );

  // ----------------------------------------
  // field statistics, latched at each vsync rise
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (vsync && !pvs)
    begin
      lvs = vsC;
      ldw = dwC;
      lcu = cuC;
      lch = chC;
      ldd = ddC;
      lhs = hsC;
      lpm = pm;
      vsC = 0;
      dwC = 0;
      cuC = 0;
      chC = 0;
      ddC = 0;
      hsC = 0;
      pm = 2'h0;
      fieldNo <= fieldNo + 1;
    end
    vsC = vsC + int'(vsync);
    dwC = dwC + int'(displayWindow);
    cuC = cuC + int'(cursorVideo);
    chC = chC + int'(refreshAddr != pAddr);
    pm = pm | (2'h1 << scanlineIndex[0]);
    ddC = ddC + int'(dwPipe[1]);
    hsC = hsC + int'(hsync);
    // video side delays the window by one character time before blanking
    dwPipe = {dwPipe[0], displayWindow};
    pvs = vsync;
    pAddr = refreshAddr;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      numErrors++;
      conclude();
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic conclude;
    if (numErrors == 0 && checkCount > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // sample before the edge so the taking edge is the one seen
  task automatic waitAcc(input int s);
    logic h;
    h = 1'b0;
    while (h !== 1'b1)
    begin
      @(negedge clk);
      h = (s == 0) ? awready : (s == 1) ? bvalid : (s == 2) ? arready : rvalid;
      sResp = (s == 1) ? bresp : rresp;
      sData = rdata;
      @(posedge clk);
    end
  endtask : waitAcc

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    waitAcc(0);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    waitAcc(1);
  endtask : wr

  task automatic rd(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    waitAcc(2);
    arvalid <= 1'b0;
    waitAcc(3);
  endtask : rd

  task automatic wreg(input logic [4:0] ix, input logic [7:0] d);
    wr(crtc_pkg::OFF_INDEX, {3'h0, ix});
    wr(crtc_pkg::OFF_DATA, d);
  endtask : wreg

  task automatic rreg(input logic [4:0] ix);
    wr(crtc_pkg::OFF_INDEX, {3'h0, ix});
    rd(crtc_pkg::OFF_DATA);
  endtask : rreg

  task automatic waitFields(input int n);
    repeat (n) @(fieldNo);
  endtask : waitFields

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    // 8 chars a line, 4 shown; 8 rows of 4 lines, 2 shown; cursor at 1, lines 1-2
    // vsync starts with row 0, so each vsync window is exactly one field
    wv = '{8'h07, 8'h04, 8'h05, 8'h01, 8'h07, 8'h00, 8'h02, 8'h00, 8'h00, 8'h03,
           8'h01, 8'h02, 8'h00, 8'h00, 8'hc0, 8'h01, 8'hff, 8'hff};
    ev = '{8'h07, 8'h04, 8'h05, 8'h01, 8'h07, 8'h00, 8'h02, 8'h00, 8'h00, 8'h03,
           8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
    cm = '{8'h21, 8'h41, 8'h61};
    nf = '{4, 32, 64};
    bx = '{0, 16, 32};
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 18; i++)
    begin
      wreg(i[4:0], wv[i]);
      rd(crtc_pkg::OFF_INDEX);
      chk("index", sData, i);
      rd(crtc_pkg::OFF_DATA);
      chk("register", sData, {24'h000000, ev[i]});
    end
    wr(4'h8, 8'h00);
    chk("bresp", {30'h0, sResp}, {30'h0, crtc_pkg::RESP_SLVERR});
    rd(4'hc);
    chk("rresp", {30'h0, sResp}, {30'h0, crtc_pkg::RESP_SLVERR});
    chk("rdata", sData, 32'h0);
    waitFields(2);
    chk("vsyncWidth", lvs, 256);
    chk("window", ldw, 64);
    chk("cursor", lcu, 4);
    chk("addrSteps", lch, 256);
    chk("parity", {30'h0, lpm}, 32'h3);
    // odd vertical total and odd max scanline keep mode 1 (sync interlace) and mode 2 (plain scan) legal
    for (int m = 1; m < 3; m++)
    begin
      wreg(crtc_pkg::IX_SCAN_MODE, m[7:0]);
      waitFields(3);
      chk("parity", {30'h0, lpm}, 32'h3);
    end
    // six-line glyphs keep a video field longer than the fixed sync pulse
    wreg(crtc_pkg::IX_MAX_SCAN, 8'h05);
    wreg(crtc_pkg::IX_SCAN_MODE, 8'h03);
    waitFields(3);
    p1 = lpm;
    waitFields(1);
    chk("fieldParity", {30'h0, lpm ^ p1}, 32'h3);
    chk("oneParity", {31'h0, ^p1}, 32'h1);
    wreg(crtc_pkg::IX_SCAN_MODE, 8'h00);
    wreg(crtc_pkg::IX_MAX_SCAN, 8'h03);
    for (int k = 0; k < 3; k++)
    begin
      wreg(crtc_pkg::IX_CUR_START, cm[k]);
      waitFields(2);
      vis = 0;
      for (int f = 0; f < nf[k]; f++)
      begin
        waitFields(1);
        vis = vis + int'(lcu != 0);
      end
      chk("blinkFields", vis, bx[k]);
    end
    wreg(crtc_pkg::IX_CUR_START, 8'h01);
    @(posedge clk);
    penArm <= 1'b1;
    waitFields(1);
    @(posedge clk);
    penArm <= 1'b0;
    rreg(crtc_pkg::IX_PEN_HI);
    chk("penHigh", sData, 32'h0);
    rreg(crtc_pkg::IX_PEN_LO);
    chk("penLow", sData, 32'h21);
    // reset in mid-frame: counters restart, programmed timing survives
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("addrInReset", {18'h0, refreshAddr}, 32'h0);
    chk("vsyncInReset", {31'h0, vsync}, 32'h0);
    nrst <= 1'b1;
    @(posedge clk);
    rd(crtc_pkg::OFF_INDEX);
    chk("indexAfterReset", sData, 32'h0);
    rreg(crtc_pkg::IX_HTOTAL);
    chk("keptTotal", sData, 32'h7);
    waitFields(2);
    chk("vsyncWidth", lvs, 256);
    chk("window", ldw, 64);
    chk("hsyncWidth", lhs, 64);
    chk("delayedWindow", ldd, 64);
    // two adjust lines: address keeps stepping, window stays closed
    wreg(crtc_pkg::IX_VADJUST, 8'h02);
    waitFields(2);
    chk("adjustSteps", lch, 272);
    chk("adjustWindow", ldw, 64);
    conclude();
  end
endmodule : tb
